// >>> epc_pkg.sv
// Package with register map, field positions and reset values of the exception pending control.
package epc_pkg;
  localparam logic [3:0]  EPC_OFF_PEND_STATE  = 4'h0;
  localparam logic [3:0]  EPC_OFF_VTAB_OFFSET = 4'h4;
  localparam logic [3:0]  EPC_OFF_IRQ_STATUS  = 4'h8;
  localparam logic [3:0]  EPC_OFF_IRQ_MASK    = 4'hC;
  localparam int          EPC_BIT_NMI_SET     = 31;
  localparam int          EPC_BIT_SVC_SET     = 28;
  localparam int          EPC_BIT_SVC_CLR     = 27;
  localparam int          EPC_BIT_TICK_SET    = 26;
  localparam int          EPC_BIT_TICK_CLR    = 25;
  localparam int          EPC_VEC_LSB         = 12;
  localparam int          EPC_VEC_MSB         = 17;
  localparam int          EPC_TBL_LSB         = 8;
  localparam int          EPC_TBL_MSB         = 31;
  localparam logic [5:0]  EPC_EXC_NMI         = 6'h02;
  localparam logic [5:0]  EPC_EXC_SVC         = 6'h0E;
  localparam logic [5:0]  EPC_EXC_TICK        = 6'h0F;
  localparam logic [5:0]  EPC_EXC_IRQ_BASE    = 6'h10;
  localparam int          EPC_NUM_IRQ         = 32;
  localparam logic [23:0] EPC_TBL_RESET       = 24'h000000;
  localparam logic [2:0]  EPC_EVT_RESET       = 3'h0;
endpackage

// >>> epc_prio_if.sv
// Interface carrying pending sources and the selected highest exception number.
`timescale 1ns/1ps
interface epc_prio_if;
  logic                   nmi_pend;
  logic                   svc_pend;
  logic                   tick_pend;
  logic [31:0]            irq_pend;
  logic [5:0]             best_num;
  modport ctrl (output nmi_pend, output svc_pend, output tick_pend, output irq_pend,
                input best_num);
  modport sel  (input nmi_pend, input svc_pend, input tick_pend, input irq_pend,
                output best_num);
endinterface

// >>> epc_prio_sel.sv
// Fixed-order selector giving the number of the highest pending enabled exception.
`timescale 1ns/1ps
module epc_prio_sel
  import epc_pkg::*;
(
  epc_prio_if.sel pif
);
  // Lower exception numbers win; external lines are scanned from the top down so
  // the lowest pending line is left standing at the end of the loop.
  always_comb begin
    pif.best_num = 6'h00;
    for (int i = EPC_NUM_IRQ - 1; i >= 0; i--) begin
      if (pif.irq_pend[i]) begin
        pif.best_num = 6'(EPC_EXC_IRQ_BASE + 6'(i));
      end
    end
    if (pif.tick_pend) begin
      pif.best_num = EPC_EXC_TICK;
    end
    if (pif.svc_pend) begin
      pif.best_num = EPC_EXC_SVC;
    end
    if (pif.nmi_pend) begin
      pif.best_num = EPC_EXC_NMI;
    end
  end
endmodule

// >>> epc_ctrl.sv
// Exception pending control and vector table offset registers with event interrupt.
`timescale 1ns/1ps
module epc_ctrl
  import epc_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Core side.
  input  wire logic        tick_event,
  input  wire logic [31:0] irq_pend_en,
  input  wire logic        nmi_taken,
  input  wire logic        svc_taken,
  input  wire logic        tick_taken,
  output logic             nmi_pending,
  output logic             svc_pending,
  output logic             tick_pending,
  output logic      [5:0]  highest_pending_number,
  output logic      [31:0] vector_table_base,
  // Interrupt.
  output logic             irq
);

  logic        nmi_ff;
  logic        svc_ff;
  logic        tick_ff;
  logic [23:0] tbl_ff;
  logic [2:0]  evt_ff;
  logic [2:0]  mask_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [2:0]  evt_set;
  logic        wr_state;
  logic        wr_vtab;
  logic        wr_status;
  logic [5:0]  best_ff;

  epc_prio_if pif ();

  epc_prio_sel u_sel (
    .pif (pif.sel)
  );

  assign pif.nmi_pend  = nmi_ff;
  assign pif.svc_pend  = svc_ff;
  assign pif.tick_pend = tick_ff;
  assign pif.irq_pend  = irq_pend_en;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  assign wr_state = reg_wr && hit(reg_addr, EPC_OFF_PEND_STATE);
  assign wr_vtab  = reg_wr && hit(reg_addr, EPC_OFF_VTAB_OFFSET);
  assign wr_status = reg_wr && hit(reg_addr, EPC_OFF_IRQ_STATUS);

  // A set arriving with handler entry wins, so a reasserted request is never lost.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_ff <= 1'b0;
    end else if (wr_state && reg_wdata[EPC_BIT_NMI_SET]) begin
      nmi_ff <= 1'b1;
    end else if (nmi_taken) begin
      nmi_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      svc_ff <= 1'b0;
    end else if (wr_state && reg_wdata[EPC_BIT_SVC_SET]) begin
      svc_ff <= 1'b1;
    end else if ((wr_state && reg_wdata[EPC_BIT_SVC_CLR]) || svc_taken) begin
      svc_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 1'b0;
    end else if ((wr_state && reg_wdata[EPC_BIT_TICK_SET]) || tick_event) begin
      tick_ff <= 1'b1;
    end else if ((wr_state && reg_wdata[EPC_BIT_TICK_CLR]) || tick_taken) begin
      tick_ff <= 1'b0;
    end
  end

  // Bits 7:0 are not stored at all, which forces the alignment in hardware.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tbl_ff <= EPC_TBL_RESET;
    end else if (wr_vtab) begin
      tbl_ff <= reg_wdata[EPC_TBL_MSB:EPC_TBL_LSB];
    end
  end

  // Events: 0 service call pended, 1 tick pended, 2 nonmaskable pended.
  assign evt_set = {~nmi_ff & (wr_state & reg_wdata[EPC_BIT_NMI_SET]),
                    ~tick_ff & ((wr_state & reg_wdata[EPC_BIT_TICK_SET]) | tick_event),
                    ~svc_ff & (wr_state & reg_wdata[EPC_BIT_SVC_SET])};

  // One sticky flag per event; a new event in the clearing cycle wins over the clear.
  for (genvar g = 0; g < 3; g++) begin : g_evt
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        evt_ff[g] <= EPC_EVT_RESET[g];
      end else if (evt_set[g]) begin
        evt_ff[g] <= 1'b1;
      end else if (wr_status && reg_wdata[g]) begin
        evt_ff[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= EPC_EVT_RESET;
    end else if (reg_wr && hit(reg_addr, EPC_OFF_IRQ_MASK)) begin
      mask_ff <= reg_wdata[2:0];
    end
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (reg_addr)
      EPC_OFF_PEND_STATE: begin
        nxt_rdata[EPC_BIT_NMI_SET]            = nmi_ff;
        nxt_rdata[EPC_BIT_SVC_SET]            = svc_ff;
        nxt_rdata[EPC_BIT_TICK_SET]           = tick_ff;
        nxt_rdata[EPC_VEC_MSB:EPC_VEC_LSB]    = pif.best_num;
      end
      EPC_OFF_VTAB_OFFSET: nxt_rdata[EPC_TBL_MSB:EPC_TBL_LSB] = tbl_ff;
      EPC_OFF_IRQ_STATUS:  nxt_rdata[2:0] = evt_ff;
      EPC_OFF_IRQ_MASK:    nxt_rdata[2:0] = mask_ff;
      default:             nxt_rdata = 32'h00000000;
    endcase
  end

  // The selector is combinational; the reported number is registered so the core sees
  // a clean level, at the cost of one cycle of lag after the pending state changes.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      best_ff <= 6'h00;
    end else begin
      best_ff <= pif.best_num;
    end
  end

  // Read data stand only in the cycle after the strobe; write-only bits read zero.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign reg_rdata              = rdata_ff;
  assign nmi_pending            = nmi_ff;
  assign svc_pending            = svc_ff;
  assign tick_pending           = tick_ff;
  assign highest_pending_number = best_ff;
  assign vector_table_base      = {tbl_ff, 8'h00};
  assign irq                    = |(evt_ff & mask_ff);

  chk_svc_only_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(svc_ff) |-> $past(wr_state && reg_wdata[EPC_BIT_SVC_SET]))
    else $error("service call pended without a set write");

  chk_svc_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_state && reg_wdata[EPC_BIT_SVC_CLR] && !reg_wdata[EPC_BIT_SVC_SET] |=> !svc_ff)
    else $error("service call clear write had no effect");

  chk_tick_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_state && reg_wdata[EPC_BIT_TICK_SET] |=> tick_ff)
    else $error("tick set write did not pend");

  sequence s_rd_state;
    reg_rd && reg_addr == EPC_OFF_PEND_STATE;
  endsequence

  chk_tick_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rd_state ##1 1'b1 |-> reg_rdata[EPC_BIT_TICK_SET] == $past(tick_ff))
    else $error("tick pending read back wrong");

  chk_svc_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rd_state ##1 1'b1 |-> reg_rdata[EPC_BIT_SVC_SET] == $past(svc_ff))
    else $error("service call pending read back wrong");

  chk_nmi_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rd_state ##1 1'b1 |-> reg_rdata[EPC_BIT_NMI_SET] == $past(nmi_ff))
    else $error("nonmaskable pending read back wrong");

  // Clear bits read as zero, so a read-modify-write never clears a pending state.
  chk_clear_bits_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rd_state |=> !reg_rdata[EPC_BIT_SVC_CLR] && !reg_rdata[EPC_BIT_TICK_CLR])
    else $error("write-only clear bits read nonzero");

  chk_tick_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_state && reg_wdata[EPC_BIT_TICK_CLR] && !reg_wdata[EPC_BIT_TICK_SET]
    && !tick_event |=> !tick_ff)
    else $error("tick clear write had no effect");

  chk_vec_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    !nmi_ff && !svc_ff && !tick_ff && irq_pend_en == 32'h00000000
    |=> highest_pending_number == 6'h00)
    else $error("pending number not zero while idle");

  chk_tbl_bit7: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_rd && reg_addr == EPC_OFF_VTAB_OFFSET |=> reg_rdata[7:0] == 8'h00)
    else $error("table offset low bits not zero");

  chk_tbl_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_vtab |=> vector_table_base[31:8] == $past(reg_wdata[31:8]))
    else $error("table offset not stored");

  chk_nmi_pend: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_state && reg_wdata[EPC_BIT_NMI_SET] |=> nmi_pending ##1 (nmi_pending || $past(nmi_taken)))
    else $error("nonmaskable not held pending");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rd_state |=> reg_rdata[30:29] == 2'h0 && reg_rdata[24:18] == 7'h00
    && reg_rdata[11:0] == 12'h000)
    else $error("reserved bits read nonzero");

  // The reported number lags the pending state by the one register stage.
  chk_vec_order: assert property (@(posedge ref_clk) disable iff (!resetn)
    nmi_ff |=> highest_pending_number == EPC_EXC_NMI)
    else $error("nonmaskable not reported as highest");

  // Outside the cycle after a read strobe the read bus is held at zero.
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read");

  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h00000000)
    else $error("unmapped address read nonzero");

  // Handler entry with no set write in the same cycle must drop the request.
  sequence s_nmi_enter;
    nmi_taken && !(wr_state && reg_wdata[EPC_BIT_NMI_SET]);
  endsequence

  chk_nmi_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_nmi_enter |=> !nmi_ff)
    else $error("nonmaskable not cleared on handler entry");

  // Each pending state that comes up must leave its sticky event flag set.
  sequence s_svc_rise;
    !svc_ff ##1 svc_ff;
  endsequence

  sequence s_tick_rise;
    !tick_ff ##1 tick_ff;
  endsequence

  sequence s_nmi_rise;
    !nmi_ff ##1 nmi_ff;
  endsequence

  chk_svc_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_svc_rise |-> evt_ff[0])
    else $error("service call event not flagged");

  chk_tick_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_tick_rise |-> evt_ff[1])
    else $error("tick event not flagged");

  chk_nmi_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_nmi_rise |-> evt_ff[2])
    else $error("nonmaskable event not flagged");

  chk_evt_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_status && reg_wdata[1] && !evt_set[1] |=> !evt_ff[1])
    else $error("tick event flag not cleared by write");

  chk_mask_store: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_wr && hit(reg_addr, EPC_OFF_IRQ_MASK) |=> mask_ff == $past(reg_wdata[2:0]))
    else $error("event mask not stored");

endmodule

// >>> tb_exception_pend_ctrl_vtable.sv
// Self-checking testbench for the exception pending control block.
`timescale 1ns/1ps
module tb_exception_pend_ctrl_vtable;
  import epc_pkg::*;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] en;
    logic [31:0] exp;
  } epc_row_t;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        tick_event = 1'b0;
  logic [31:0] irq_pend_en = 32'h0;
  logic        nmi_taken = 1'b0;
  logic        svc_taken = 1'b0;
  logic        tick_taken = 1'b0;
  logic        nmi_pending;
  logic        svc_pending;
  logic        tick_pending;
  logic [5:0]  highest_pending_number;
  logic [31:0] vector_table_base;
  logic        irq;
  int          miscompares = 0;
  int          num_checks = 0;
  epc_row_t    rows [11];

  always #50 ref_clk = ~ref_clk;

  epc_ctrl u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tick_event(tick_event), .irq_pend_en(irq_pend_en), .nmi_taken(nmi_taken),
    .svc_taken(svc_taken), .tick_taken(tick_taken), .nmi_pending(nmi_pending),
    .svc_pending(svc_pending), .tick_pending(tick_pending),
    .highest_pending_number(highest_pending_number),
    .vector_table_base(vector_table_base), .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Each task returns just after the edge that took the strobe, effects settled.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Bits 25 and 27 are write-only, so their read value is not compared.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] m;
    m = (a == EPC_OFF_PEND_STATE) ? 32'hF5FFFFFF : 32'hFFFFFFFF;
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp & m);
  endtask

  // One-cycle core strobes, from the top bit: tick_event, nmi_taken, svc_taken, tick_taken.
  task automatic pulse(input logic [3:0] which);
    @(posedge ref_clk);
    {tick_event, nmi_taken, svc_taken, tick_taken} <= which;
    @(posedge ref_clk);
    {tick_event, nmi_taken, svc_taken, tick_taken} <= 4'h0;
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    rows[0]  = '{4'h4, 32'hFFFFFFFF, 32'h0, 32'hFFFFFF00};
    rows[1]  = '{4'h4, 32'h00001280, 32'h0, 32'h00001200};
    rows[2]  = '{4'h0, 32'h61FFFFFF, 32'h0, 32'h00000000};
    rows[3]  = '{4'h0, 32'h04000000, 32'h0, 32'h0400F000};
    rows[4]  = '{4'h0, 32'h00000000, 32'h0, 32'h0400F000};
    rows[5]  = '{4'h0, 32'h10000000, 32'h0, 32'h1400E000};
    rows[6]  = '{4'h0, 32'h08000000, 32'h0, 32'h0400F000};
    rows[7]  = '{4'h0, 32'h02000000, 32'h0, 32'h00000000};
    rows[8]  = '{4'h0, 32'h00000000, 32'h8, 32'h00013000};
    rows[9]  = '{4'h0, 32'h80000000, 32'h8, 32'h80002000};
    rows[10] = '{4'h2, 32'hFFFFFFFF, 32'h0, 32'h00000000};
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(EPC_OFF_PEND_STATE, 32'h0);
    rd(EPC_OFF_VTAB_OFFSET, 32'h0);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      irq_pend_en <= rows[i].en;
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    chk(vector_table_base, 32'h00001200);
    chk({26'h0, highest_pending_number}, 32'h2);
    wr(EPC_OFF_VTAB_OFFSET, 32'h00000100);
    chk(vector_table_base, 32'h00000100);
    @(posedge ref_clk);
    irq_pend_en <= 32'h0;
    pulse(4'h4);
    chk(32'(nmi_pending), 32'h0);
    rd(EPC_OFF_PEND_STATE, 32'h0);
    rd(EPC_OFF_IRQ_STATUS, 32'h7);
    chk(32'(irq), 32'h0);
    wr(EPC_OFF_IRQ_MASK, 32'h2);
    chk(32'(irq), 32'h1);
    wr(EPC_OFF_IRQ_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    rd(EPC_OFF_IRQ_STATUS, 32'h5);
    // Hardware tick must not touch the service-call pending state.
    pulse(4'h8);
    chk({30'h0, tick_pending, svc_pending}, 32'h2);
    chk(32'(irq), 32'h1);
    pulse(4'h1);
    chk(32'(tick_pending), 32'h0);
    wr(EPC_OFF_PEND_STATE, 32'h10000000);
    chk(32'(svc_pending), 32'h1);
    pulse(4'h2);
    rd(EPC_OFF_PEND_STATE, 32'h0);
    // Leave pending states and an unmasked event up, then reset in mid-run.
    wr(EPC_OFF_PEND_STATE, 32'h84000000);
    chk({29'h0, nmi_pending, tick_pending, irq}, 32'h7);
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({vector_table_base[31:1], irq}, 32'h0);
    chk({24'h0, highest_pending_number, nmi_pending, tick_pending}, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'b1;
    rd(EPC_OFF_PEND_STATE, 32'h0);
    rd(EPC_OFF_IRQ_STATUS, 32'h0);
    end_of_test();
  end
endmodule
